/* File: rtl/cms_core_map.sv */
`timescale 1ns/1ps
module cms_core_map
    import cms_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic power_on_in,
    input wire logic watchdog_rst_in,
    input wire logic loader_no_cmd_in,
    input wire logic loader_data_en_in,
    input wire logic prog_running_loader_in,
    input wire logic prog_trig_in,
    input wire cms_region_t prog_target_in,
    input wire logic [15:0] fetch_addr_in,
    input wire logic fetch_ext_in,
    input wire logic [1:0] irq_num_in,
    input wire logic irq_take_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic indirect_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic bit_wr_in,
    input wire logic bit_rd_in,
    input wire logic [7:0] bit_addr_in,
    input wire logic bit_val_in,
    input wire logic [2:0] reg_num_in,
    input wire logic reg_wr_in,
    input wire logic push_in,
    input wire logic pop_in,
    input wire cms_op_t op_in,
    input wire logic [7:0] op_b_in,
    output logic [7:0] rdata_out,
    output logic bit_rdata_out,
    output logic [7:0] reg_rdata_out,
    output logic [7:0] pop_data_out,
    output logic [7:0] psw_out,
    output logic [7:0] sp_out,
    output logic [7:0] acc_out,
    output logic run_loader_out,
    output logic [15:0] pc_load_out,
    output logic pc_load_valid_out,
    output logic [15:0] ext_fetch_addr_out,
    output logic ext_fetch_out,
    output logic flash_go_out,
    output logic flash_refused_out
);
    typedef struct packed {
        logic [7:0] program_status_word;
        logic [7:0] sp;
        logic [7:0] acc;
        logic [7:0] boot_ctl;
        logic run_loader;
        logic [15:0] pc_load;
        logic pc_load_valid;
        logic [7:0] rdata;
        logic bit_rdata;
        logic [7:0] reg_rdata;
        logic [7:0] pop_data;
        logic [15:0] ext_addr;
        logic ext_fetch;
        logic flash_go;
        logic flash_refused;
    } cms_state_t;

    cms_state_t cur;
    cms_state_t nxt;
    logic [7:0] ram [0:255];
    logic alu_carry;
    logic alu_half;
    logic alu_exceed;
    logic boot_wr;
    logic [7:0] alu_res;
    logic [7:0] reg_addr;
    logic [7:0] bit_byte;
    logic [7:0] ram_wa;
    logic [7:0] ram_wd;
    logic ram_we;
    logic sfr_direct;
    logic permit;

    cms_flags u_flags (
        .op_in(op_in),
        .a_in(cur.acc),
        .b_in(op_b_in),
        .carry_in(cur.program_status_word[CMS_CARRY_POS]),
        .carry_out(alu_carry),
        .half_out(alu_half),
        .exceed_out(alu_exceed),
        .res_out(alu_res)
    );

    assign reg_addr = {3'b000, cur.program_status_word[CMS_BANK_HI_POS], cur.program_status_word[CMS_BANK_LO_POS], reg_num_in};
    assign bit_byte = CMS_BIT_BYTE_BASE + {4'h0, bit_addr_in[6:3]};
    // direct upper half is special space
    assign sfr_direct = !indirect_in && (addr_in >= CMS_UPPER_BASE);
    assign boot_wr = wr_in && sfr_direct && (addr_in == CMS_BOOT_CTL_ADDR);

    always_comb begin
        unique case (prog_target_in)
            CMS_REG_USER: permit = prog_running_loader_in;
            CMS_REG_DATA: permit = 1'b1;
            CMS_REG_LOADER: permit = prog_running_loader_in && loader_data_en_in;
            CMS_REG_NONE: permit = 1'b0;
        endcase
    end

    // ram write port selection
    always_comb begin
        ram_we = 1'b0;
        ram_wa = 8'h00;
        ram_wd = 8'h00;
        if (push_in) begin
            ram_we = 1'b1;
            ram_wa = cur.sp + 8'h01;
            ram_wd = wdata_in;
        end else if (reg_wr_in) begin
            ram_we = 1'b1;
            ram_wa = reg_addr;
            ram_wd = wdata_in;
        end else if (bit_wr_in && !bit_addr_in[7]) begin
            ram_we = 1'b1;
            ram_wa = bit_byte;
            ram_wd = ram[bit_byte];
            ram_wd[bit_addr_in[2:0]] = bit_val_in;
        end else if (wr_in && !sfr_direct) begin
            // lower half direct or indirect, upper indirect
            ram_we = 1'b1;
            ram_wa = addr_in;
            ram_wd = wdata_in;
        end
    end

    // next state
    always_comb begin
        nxt = cur;
        nxt.pc_load_valid = 1'b0;
        nxt.flash_go = 1'b0;
        nxt.flash_refused = 1'b0;
        nxt.ext_fetch = 1'b0;
        // fetches read only, full 16-bit external space
        if (fetch_ext_in) begin
            nxt.ext_fetch = 1'b1;
            nxt.ext_addr = fetch_addr_in;
        end
        if (irq_take_in) begin
            nxt.pc_load = CMS_VEC_EXT0 + {11'h000, irq_num_in, 3'b000};
            nxt.pc_load_valid = 1'b1;
        end
        if (prog_trig_in) begin
            nxt.flash_go = permit;
            nxt.flash_refused = !permit;
        end
        unique case (op_in)
            CMS_OP_ADD, CMS_OP_ADDC, CMS_OP_SUBB: begin
                nxt.acc = alu_res;
                nxt.program_status_word[CMS_CARRY_POS] = alu_carry;
                nxt.program_status_word[CMS_HALF_POS] = alu_half;
                nxt.program_status_word[CMS_EXCEED_POS] = alu_exceed;
            end
            CMS_OP_MUL, CMS_OP_DIV: begin
                nxt.acc = alu_res;
                nxt.program_status_word[CMS_CARRY_POS] = 1'b0;
                nxt.program_status_word[CMS_EXCEED_POS] = alu_exceed;
            end
            CMS_OP_OTHER: begin
                nxt.program_status_word[CMS_CARRY_POS] = 1'b0;
                nxt.program_status_word[CMS_HALF_POS] = 1'b0;
            end
            default: begin
            end
        endcase
        // special register writes, user flags by software only
        if (wr_in && sfr_direct) begin
            if (addr_in == CMS_PSW_ADDR) begin
                nxt.program_status_word[7:1] = wdata_in[7:1];
            end else if (addr_in == CMS_SP_ADDR) begin
                nxt.sp = wdata_in;
            end
        end
        if (bit_wr_in && bit_addr_in[7] && ({bit_addr_in[7:3], 3'b000} == CMS_PSW_ADDR)
            && bit_addr_in[2:0] != 3'(CMS_P)) begin
            nxt.program_status_word[bit_addr_in[2:0]] = bit_val_in;
        end
        if (push_in) begin
            nxt.sp = cur.sp + 8'h01;
        end else if (pop_in) begin
            nxt.pop_data = ram[cur.sp];
            nxt.sp = cur.sp - 8'h01;
        end
        nxt.program_status_word[CMS_P] = ^nxt.acc;
        // read paths
        if (rd_in) begin
            nxt.rdata = ram[addr_in];
            if (sfr_direct) begin
                nxt.rdata = (addr_in == CMS_PSW_ADDR) ? cur.program_status_word
                    : (addr_in == CMS_SP_ADDR) ? cur.sp
                    : (addr_in == CMS_BOOT_CTL_ADDR) ? cur.boot_ctl : 8'h00;
            end
        end
        if (bit_rd_in) begin
            nxt.bit_rdata = bit_addr_in[7]
                ? (({bit_addr_in[7:3], 3'b000} == CMS_PSW_ADDR) & cur.program_status_word[bit_addr_in[2:0]])
                : ram[bit_byte][bit_addr_in[2:0]];
        end
        nxt.reg_rdata = ram[reg_addr];
        // boot control keeps the last value written
        if (boot_wr) begin
            nxt.boot_ctl = wdata_in;
        end
        // watchdog outranks a software restart in the same cycle
        if (watchdog_rst_in) begin
            nxt.run_loader = 1'b0;
            nxt.pc_load = CMS_RESET_VECTOR;
            nxt.pc_load_valid = 1'b1;
        end else if (boot_wr && wdata_in == CMS_BOOT_USER_CMD) begin
            nxt.run_loader = 1'b0;
            nxt.pc_load = CMS_RESET_VECTOR;
            nxt.pc_load_valid = 1'b1;
        end else if (boot_wr && wdata_in == CMS_BOOT_LOADER_CMD) begin
            nxt.run_loader = 1'b1;
            nxt.pc_load = CMS_RESET_VECTOR;
            nxt.pc_load_valid = 1'b1;
        end else if (loader_no_cmd_in && cur.run_loader) begin
            nxt.run_loader = 1'b0;
            nxt.pc_load = CMS_RESET_VECTOR;
            nxt.pc_load_valid = 1'b1;
        end
    end

    // state register, reset kind selects boot region
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            cur <= '0;
            cur.sp <= CMS_SP_RESET;
            cur.program_status_word <= CMS_PSW_RESET;
            // power-on runs the loader, a pin reset runs user code
            cur.run_loader <= power_on_in;
            cur.pc_load_valid <= 1'b1;
        end else begin
            cur <= nxt;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (ram_we) begin
            ram[ram_wa] <= ram_wd;
        end
    end

    // outputs from flops
    assign rdata_out = cur.rdata;
    assign bit_rdata_out = cur.bit_rdata;
    assign reg_rdata_out = cur.reg_rdata;
    assign pop_data_out = cur.pop_data;
    assign psw_out = cur.program_status_word;
    assign sp_out = cur.sp;
    assign acc_out = cur.acc;
    assign run_loader_out = cur.run_loader;
    assign pc_load_out = cur.pc_load;
    assign pc_load_valid_out = cur.pc_load_valid;
    assign ext_fetch_addr_out = cur.ext_addr;
    assign ext_fetch_out = cur.ext_fetch;
    assign flash_go_out = cur.flash_go;
    assign flash_refused_out = cur.flash_refused;
endmodule : cms_core_map

/* File: common/cms_pkg.sv */
package cms_pkg;
    // boot control values and reset vector
    localparam logic [7:0] CMS_BOOT_USER_CMD = 8'h20;
    localparam logic [7:0] CMS_BOOT_LOADER_CMD = 8'h60;
    localparam logic [15:0] CMS_RESET_VECTOR = 16'h0000;
    // interrupt vectors
    localparam logic [15:0] CMS_VEC_EXT0 = 16'h0003;
    localparam logic [15:0] CMS_VEC_STEP = 16'h0008;
    // direct address map
    localparam logic [7:0] CMS_UPPER_BASE = 8'h80;
    localparam logic [7:0] CMS_BIT_BYTE_BASE = 8'h20;
    localparam logic [7:0] CMS_PSW_ADDR = 8'hd0;
    localparam logic [7:0] CMS_SP_ADDR = 8'h81;
    localparam logic [7:0] CMS_BOOT_CTL_ADDR = 8'he7;
    localparam logic [7:0] CMS_SP_RESET = 8'h07;
    localparam logic [7:0] CMS_PSW_RESET = 8'h00;
    // status word bit positions
    localparam int CMS_CARRY_POS = 7;
    localparam int CMS_HALF_POS = 6;
    localparam int CMS_USER0_POS = 5;
    localparam int CMS_BANK_HI_POS = 4;
    localparam int CMS_BANK_LO_POS = 3;
    localparam int CMS_EXCEED_POS = 2;
    localparam int CMS_USER1_POS = 1;
    localparam int CMS_P = 0;
    // flash regions
    typedef enum logic [1:0] {
        CMS_REG_USER,
        CMS_REG_DATA,
        CMS_REG_LOADER,
        CMS_REG_NONE
    } cms_region_t;
    // arithmetic op classes
    typedef enum logic [2:0] {
        CMS_OP_NONE,
        CMS_OP_ADD,
        CMS_OP_ADDC,
        CMS_OP_SUBB,
        CMS_OP_MUL,
        CMS_OP_DIV,
        CMS_OP_OTHER
    } cms_op_t;
endpackage : cms_pkg

/* File: rtl/cms_flags.sv */
`timescale 1ns/1ps
// arithmetic flag evaluator
module cms_flags
    import cms_pkg::*;
(
    input wire cms_op_t op_in,
    input wire logic [7:0] a_in,
    input wire logic [7:0] b_in,
    input wire logic carry_in,
    output logic carry_out,
    output logic half_out,
    output logic exceed_out,
    output logic [7:0] res_out
);
    logic [8:0] sum;
    logic [4:0] nib;
    logic [15:0] prod;
    always_comb begin
        sum = 9'h000;
        nib = 5'h00;
        prod = 16'h0000;
        carry_out = 1'b0;
        half_out = 1'b0;
        exceed_out = 1'b0;
        res_out = 8'h00;
        unique case (op_in)
            CMS_OP_ADD, CMS_OP_ADDC: begin
                sum = {1'b0, a_in} + {1'b0, b_in} + {8'h00, carry_in & (op_in == CMS_OP_ADDC)};
                nib = {1'b0, a_in[3:0]} + {1'b0, b_in[3:0]}
                    + {4'h0, carry_in & (op_in == CMS_OP_ADDC)};
                res_out = sum[7:0];
                carry_out = sum[8];
                half_out = nib[4];
                exceed_out = (a_in[7] == b_in[7]) && (sum[7] != a_in[7]);
            end
            CMS_OP_SUBB: begin
                sum = {1'b0, a_in} - {1'b0, b_in} - {8'h00, carry_in};
                nib = {1'b0, a_in[3:0]} - {1'b0, b_in[3:0]} - {4'h0, carry_in};
                res_out = sum[7:0];
                carry_out = sum[8];
                half_out = nib[4];
                exceed_out = (a_in[7] != b_in[7]) && (sum[7] != a_in[7]);
            end
            CMS_OP_MUL: begin
                prod = {8'h00, a_in} * {8'h00, b_in};
                res_out = prod[7:0];
                exceed_out = (prod[15:8] != 8'h00);
            end
            CMS_OP_DIV: begin
                exceed_out = (b_in == 8'h00);
                res_out = (b_in == 8'h00) ? 8'h00 : a_in / b_in;
            end
            default: begin
                res_out = a_in;
            end
        endcase
    end
endmodule : cms_flags

/* File: verification/cms_core_map_chk.sv */
`timescale 1ns/1ps
// port-level checks on the core map
module cms_core_map_chk
    import cms_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic power_on_in,
    input wire logic watchdog_rst_in,
    input wire logic loader_no_cmd_in,
    input wire logic loader_data_en_in,
    input wire logic prog_running_loader_in,
    input wire logic prog_trig_in,
    input wire cms_region_t prog_target_in,
    input wire logic [1:0] irq_num_in,
    input wire logic irq_take_in,
    input wire logic wr_in,
    input wire logic bit_wr_in,
    input wire logic push_in,
    input wire logic pop_in,
    input wire logic [7:0] psw_out,
    input wire logic [7:0] sp_out,
    input wire logic [7:0] acc_out,
    input wire logic run_loader_out,
    input wire logic [15:0] pc_load_out,
    input wire logic pc_load_valid_out,
    input wire logic flash_go_out,
    input wire logic flash_refused_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);

    // stack, restart and vector checks
    AST_SP_PUSH: assert property (push_in && !wr_in |=> sp_out == $past(sp_out) + 8'h01)
        else $error("push did not raise the stack pointer");
    AST_SP_POP: assert property (pop_in && !push_in && !wr_in
        |=> sp_out == $past(sp_out) - 8'h01)
        else $error("pop did not lower the stack pointer");
    AST_SP_RESET: assert property ($fell(reset_in)
        |-> sp_out == 8'h07 && run_loader_out == $past(power_on_in))
        else $error("bad state after reset");
    AST_IRQ_VEC: assert property (irq_take_in
        |=> pc_load_valid_out && pc_load_out == 16'h0003 + {11'h000, $past(irq_num_in), 3'h0})
        else $error("wrong interrupt vector");
    AST_WATCHDOG: assert property (watchdog_rst_in
        |=> !run_loader_out && pc_load_valid_out && pc_load_out == 16'h0000)
        else $error("watchdog did not restart user code");
    AST_SOFT_BOOT: assert property (loader_no_cmd_in && run_loader_out |=> !run_loader_out)
        else $error("loader did not hand over");
    // flash region guard
    AST_FLASH_USER: assert property (prog_trig_in && prog_target_in == CMS_REG_USER
        |=> flash_go_out == $past(prog_running_loader_in))
        else $error("user region guard wrong");
    AST_FLASH_DATA: assert property (prog_trig_in && prog_target_in == CMS_REG_DATA
        |=> flash_go_out && !flash_refused_out)
        else $error("data region guard wrong");
    AST_FLASH_LOADER: assert property (prog_trig_in && prog_target_in == CMS_REG_LOADER
        |=> flash_go_out == ($past(prog_running_loader_in) && $past(loader_data_en_in)))
        else $error("loader region guard wrong");
    AST_FLASH_NONE: assert property (prog_trig_in && prog_target_in == CMS_REG_NONE
        |=> flash_refused_out && !flash_go_out)
        else $error("out of range trigger not refused");
    AST_FLASH_IDLE: assert property (!prog_trig_in |=> !flash_go_out && !flash_refused_out)
        else $error("flash result without trigger");
    // status word flags
    AST_PARITY: assert property (psw_out[0] == ^acc_out)
        else $error("parity does not follow accumulator");
    AST_USER_FLAGS: assert property (!bit_wr_in && !wr_in
        |=> $stable(psw_out[5]) && $stable(psw_out[1]))
        else $error("user flag changed by hardware");
endmodule : cms_core_map_chk

bind cms_core_map cms_core_map_chk i_chk (.*);

/* File: verification/test_core_memory_map_and_status.sv */
`timescale 1ns/1ps
// self-checking bench for the core map
module test_core_memory_map_and_status;
    import cms_pkg::*;
    logic core_clk_in = 1'b0, reset_in = 1'b1, power_on_in = 1'b1, watchdog_rst_in = 1'b0;
    logic loader_no_cmd_in = 1'b0, loader_data_en_in = 1'b0, prog_running_loader_in = 1'b0;
    logic prog_trig_in = 1'b0, fetch_ext_in = 1'b0, irq_take_in = 1'b0, wr_in = 1'b0;
    logic rd_in = 1'b0, indirect_in = 1'b0, bit_wr_in = 1'b0, bit_rd_in = 1'b0;
    logic bit_val_in = 1'b0, reg_wr_in = 1'b0, push_in = 1'b0, pop_in = 1'b0;
    logic [1:0] irq_num_in = 2'h0;
    logic [2:0] reg_num_in = 3'h0;
    logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, bit_addr_in = 8'h00, op_b_in = 8'h00;
    logic [15:0] fetch_addr_in = 16'h0000;
    cms_region_t prog_target_in = CMS_REG_USER;
    cms_op_t op_in = CMS_OP_NONE;
    logic [7:0] rdata_out, reg_rdata_out, pop_data_out, psw_out, sp_out, acc_out;
    logic bit_rdata_out, run_loader_out, pc_load_valid_out, ext_fetch_out;
    logic flash_go_out, flash_refused_out, exp_go;
    logic [15:0] pc_load_out, ext_fetch_addr_out;
    int n_fail = 0, n_compared = 0;

    // 125 MHz core clock
    always #4 core_clk_in = ~core_clk_in;

    cms_core_map i_dut (.*);

    // compare one value
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
        n_compared++;
        if (got !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, e, got);
        end
    endtask : chk
    // one cycle passes, pulses drop
    task automatic tick;
        @(negedge core_clk_in);
        {watchdog_rst_in, loader_no_cmd_in, prog_trig_in, fetch_ext_in, irq_take_in} = 5'h00;
        {wr_in, rd_in, bit_wr_in, bit_rd_in, reg_wr_in, push_in, pop_in} = 7'h00;
        op_in = CMS_OP_NONE;
    endtask : tick
    // byte write and read
    task automatic wr(input logic ind, input logic [7:0] a, input logic [7:0] d);
        indirect_in = ind;
        addr_in = a;
        wdata_in = d;
        wr_in = 1'b1;
        tick();
    endtask : wr
    task automatic rd(input logic ind, input logic [7:0] a, input logic [7:0] e);
        indirect_in = ind;
        addr_in = a;
        rd_in = 1'b1;
        tick();
        chk("read data", {8'h00, e}, {8'h00, rdata_out});
    endtask : rd
    // one arithmetic step, masked status check
    task automatic arith(input cms_op_t op, input logic [7:0] b, input logic [7:0] a_e,
                         input logic [7:0] p_e, input logic [7:0] m);
        op_in = op;
        op_b_in = b;
        tick();
        chk("status", {8'h00, p_e & m}, {8'h00, psw_out & m});
        if (op <= CMS_OP_SUBB) begin
            chk("acc", {8'h00, a_e}, {8'h00, acc_out});
        end
    endtask : arith
    // verdict
    task automatic conclude;
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    // hang guard
    initial begin
        #40000;
        n_fail++;
        conclude();
    end

    // test sequence
    initial begin
        repeat (4) @(posedge core_clk_in);
        @(negedge core_clk_in);
        reset_in = 1'b0;
        power_on_in = 1'b0;
        tick();
        chk("sp", 16'h0007, {8'h00, sp_out});
        chk("loader", 16'h0001, {15'h0000, run_loader_out});
        wdata_in = 8'haa;
        push_in = 1'b1;
        tick();
        chk("sp", 16'h0008, {8'h00, sp_out});
        rd(1'b1, 8'h08, 8'haa);
        pop_in = 1'b1;
        tick();
        chk("pop", 16'h00aa, {8'h00, pop_data_out});
        chk("sp", 16'h0007, {8'h00, sp_out});
        wr(1'b0, CMS_SP_ADDR, 8'hff);
        wdata_in = 8'h5c;
        push_in = 1'b1;
        tick();
        chk("sp", 16'h0000, {8'h00, sp_out});
        rd(1'b1, 8'h00, 8'h5c);
        for (int b = 0; b < 4; b++) begin
            wr(1'b0, CMS_PSW_ADDR, {3'h0, 2'(b), 3'h0});
            reg_num_in = 3'(b + 1);
            wdata_in = 8'h40 + 8'(b);
            reg_wr_in = 1'b1;
            tick();
            rd(1'b0, 8'(9 * b + 1), 8'h40 + 8'(b));
            chk("reg", {8'h00, 8'h40 + 8'(b)}, {8'h00, reg_rdata_out});
        end
        wr(1'b1, 8'h90, 8'h3c);
        wr(1'b0, 8'h90, 8'h55);
        rd(1'b1, 8'h90, 8'h3c);
        rd(1'b0, 8'h90, 8'h00);
        wr(1'b0, 8'h45, 8'h77);
        rd(1'b1, 8'h45, 8'h77);
        wr(1'b0, 8'h21, 8'h00);
        bit_val_in = 1'b1;
        bit_addr_in = 8'h0f;
        bit_wr_in = 1'b1;
        tick();
        rd(1'b0, 8'h21, 8'h80);
        bit_rd_in = 1'b1;
        tick();
        chk("bit", 16'h0001, {15'h0000, bit_rdata_out});
        wr(1'b0, CMS_PSW_ADDR, 8'h00);
        bit_addr_in = 8'hd5;
        bit_wr_in = 1'b1;
        tick();
        bit_addr_in = 8'hd1;
        bit_wr_in = 1'b1;
        tick();
        chk("psw", 16'h0022, {8'h00, psw_out});
        arith(CMS_OP_ADD, 8'h80, 8'h80, 8'h23, 8'he7);
        arith(CMS_OP_ADD, 8'h80, 8'h00, 8'ha6, 8'he7);
        arith(CMS_OP_ADD, 8'h0f, 8'h0f, 8'h22, 8'he7);
        arith(CMS_OP_ADD, 8'h01, 8'h10, 8'h63, 8'he7);
        arith(CMS_OP_SUBB, 8'h11, 8'hff, 8'he2, 8'he7);
        arith(CMS_OP_ADDC, 8'h01, 8'h01, 8'he3, 8'he7);
        arith(CMS_OP_MUL, 8'hff, 8'h00, 8'h22, 8'ha6);
        arith(CMS_OP_MUL, 8'h02, 8'h00, 8'h26, 8'ha6);
        arith(CMS_OP_DIV, 8'h00, 8'h00, 8'h26, 8'ha6);
        arith(CMS_OP_DIV, 8'h01, 8'h00, 8'h22, 8'ha6);
        for (int i = 0; i < 16; i++) begin
            prog_running_loader_in = i[0];
            loader_data_en_in = i[1];
            prog_target_in = cms_region_t'(i[3:2]);
            exp_go = prog_target_in == CMS_REG_DATA || (prog_target_in == CMS_REG_USER && i[0])
                || (prog_target_in == CMS_REG_LOADER && i[0] && i[1]);
            prog_trig_in = 1'b1;
            tick();
            chk("go", {15'h0000, exp_go}, {15'h0000, flash_go_out});
            chk("refused", {15'h0000, !exp_go}, {15'h0000, flash_refused_out});
        end
        for (int n = 0; n < 4; n++) begin
            irq_num_in = 2'(n);
            irq_take_in = 1'b1;
            tick();
            chk("vector", CMS_VEC_EXT0 + 16'(8 * n), pc_load_out);
            chk("vector valid", 16'h0001, {15'h0000, pc_load_valid_out});
        end
        fetch_addr_in = 16'hfffe;
        fetch_ext_in = 1'b1;
        tick();
        chk("fetch", 16'hfffe, ext_fetch_addr_out);
        chk("fetch strobe", 16'h0001, {15'h0000, ext_fetch_out});
        wr(1'b0, 8'he7, CMS_BOOT_USER_CMD);
        chk("loader", 16'h0000, {15'h0000, run_loader_out});
        chk("restart", CMS_RESET_VECTOR, pc_load_out);
        wr(1'b0, 8'he7, CMS_BOOT_LOADER_CMD);
        chk("loader", 16'h0001, {15'h0000, run_loader_out});
        rd(1'b0, 8'he7, CMS_BOOT_LOADER_CMD);
        loader_no_cmd_in = 1'b1;
        tick();
        chk("loader", 16'h0000, {15'h0000, run_loader_out});
        wr(1'b0, 8'he7, CMS_BOOT_LOADER_CMD);
        watchdog_rst_in = 1'b1;
        tick();
        chk("loader", 16'h0000, {15'h0000, run_loader_out});
        chk("restart", 16'h0001, {15'h0000, pc_load_valid_out});
        push_in = 1'b1;
        tick();
        reset_in = 1'b1;
        tick();
        reset_in = 1'b0;
        tick();
        chk("sp", 16'h0007, {8'h00, sp_out});
        chk("loader", 16'h0000, {15'h0000, run_loader_out});
        power_on_in = 1'b1;
        reset_in = 1'b1;
        tick();
        reset_in = 1'b0;
        power_on_in = 1'b0;
        tick();
        chk("loader", 16'h0001, {15'h0000, run_loader_out});
        conclude();
    end
endmodule : test_core_memory_map_and_status
